// [core/rbc_pkg.sv]
// Constants shared by the reset, boot and clock sequencer.
// Assumes a single 125 MHz clock and straps that stay fixed while powered.
package rbc_pkg;

   // ----------------------------------------
   // Clock rate and reset-complete timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int RST_DONE_NS = 1000;
   // Least time, so round up to whole cycles
   localparam int RST_DONE_CYCLES = (RST_DONE_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------
   // Strap ratio table
   // ----------------------------------------
   localparam logic [2:0] RATIO_RESERVED = 3'h7;
   localparam logic [3:0] RATIO_DEFAULT = 4'h4;
   localparam logic [3:0] RATIO_X5 = 4'h5;
   localparam logic [3:0] RATIO_X6 = 4'h6;
   localparam logic [3:0] RATIO_X7 = 4'h7;
   localparam logic [3:0] RATIO_X8 = 4'h8;
   localparam logic [3:0] RATIO_X10 = 4'ha;
   localparam logic [3:0] RATIO_X12 = 4'hc;

   // ----------------------------------------
   // Boot methods and no-boot start addresses
   // ----------------------------------------
   typedef enum logic [1:0] {
      BOOT_EPROM = 2'b00,
      BOOT_HOST = 2'b01,
      BOOT_LINK = 2'b10,
      BOOT_NONE = 2'b11
   } boot_mode_t;

   localparam logic [31:0] START_LINE0 = 32'h3000_0000;
   localparam logic [31:0] START_LINE1 = 32'h3800_0000;
   localparam logic [31:0] START_LINE2 = 32'h8000_0000;
   localparam logic [31:0] START_LINE3 = 32'h0000_0000;
   localparam logic [31:0] START_LOADED = 32'h0000_0000;

   // Interrupts enabled by hardware on reset exit
   localparam logic [3:0] IRQ_EN_RESET = 4'hf;

   // ----------------------------------------
   // Core sequencing states
   // ----------------------------------------
   typedef enum logic [1:0] {
      CORE_HELD = 2'b00,
      CORE_IDLE = 2'b01,
      CORE_RUN = 2'b10
   } core_state_t;

   // Divider widths
   localparam int LINK_DIV_W = 4;

endpackage : rbc_pkg

// [core/reset_boot_clock_sequencer.sv]
// Reset levels, boot selection and clock-rate enables for a DSP.
// Assumes sys_clk is the multiplied core clock, all inputs synchronous to it,
// and straps stable before rst_n is first driven low.
// How it works
// - Any later chip reset is requested with rst_n low and fully reinitialises.
// - Core soft-reset bit resets only the core; dividers and I/O keep running.
// - Four start-up methods: EPROM, external master, link port, or no boot.
// - No boot: execution starts on a boot interrupt, address set by the line.
// - No boot, line 1 starts execution at external address 0x3800_0000.
// - No boot, line 3 starts execution at internal address 0x0000_0000.
// - Core leaves reset idle, executing nothing until an interrupt arrives; loader modes start it on loader_done instead.
// - Some interrupt vectors are enabled by hardware on reset exit.
// - Core rate is system rate times the strap-selected multiplier.
// - One instruction cycle per core clock.
// - Link clock is core clock divided by a software-programmed divisor.
// - On-chip bus runs at half core rate; buffer transfers use that rate.
// - External bus logic is timed on the system-clock rate.
// - Straps 000..110 map to 4,5,6,7,8,10,12; 111 is reserved.
// - Device drives a reset-complete output when internal reset ends.
`timescale 1ns/1ns
module reset_boot_clock_sequencer
   import rbc_pkg::*;
#(
   parameter int DONE_CYCLES = RST_DONE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] core_ratio_straps,
   input wire logic [1:0] boot_mode,
   input wire logic [3:0] boot_interrupt_lines,
   input wire logic core_soft_reset_bit,
   input wire logic por_in_n,
   input wire logic loader_done,
   input wire logic [LINK_DIV_W-1:0] link_divisor,
   output logic reset_done_n_ff,
   output logic core_reset_n_ff,
   output logic dram_ready_ff,
   output logic [3:0] core_ratio_ff,
   output logic ratio_reserved_ff,
   output logic instr_en_ff,
   output logic onchip_bus_clock_en_ff,
   output logic ext_bus_en_ff,
   output logic link_clk_en_ff,
   output logic loader_start_ff,
   output logic core_run_ff,
   output logic [31:0] start_addr_ff,
   output logic [3:0] irq_enable_ff
);

   // Refuse a completion count that the 16-bit counter cannot reach
   if (DONE_CYCLES < 1 || DONE_CYCLES > 65535) begin : g_bad_done
      $error("DONE_CYCLES out of range");
   end

   // ----------------------------------------
   // Reset-complete counter
   // ----------------------------------------
   logic [15:0] done_cnt_ff;
   logic strap_taken_ff;

   // Full chip reset restarts the count; the core is not involved here
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_cnt_ff <= 16'h0000;
         reset_done_n_ff <= 1'b0;
      end else if (done_cnt_ff == 16'(DONE_CYCLES)) begin
         reset_done_n_ff <= 1'b1;
      end else begin
         done_cnt_ff <= done_cnt_ff + 16'h0001;
      end
   end

   // DRAM is usable once its power-on reset input is released
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dram_ready_ff <= 1'b0;
      end else begin
         dram_ready_ff <= por_in_n;
      end
   end

   // ----------------------------------------
   // Strap capture and ratio decode
   // ----------------------------------------
   logic [3:0] nxt_ratio;

   // Straps are static, so one decode after release is enough
   always_comb begin
      unique case (core_ratio_straps)
         3'h0: nxt_ratio = RATIO_DEFAULT;
         3'h1: nxt_ratio = RATIO_X5;
         3'h2: nxt_ratio = RATIO_X6;
         3'h3: nxt_ratio = RATIO_X7;
         3'h4: nxt_ratio = RATIO_X8;
         3'h5: nxt_ratio = RATIO_X10;
         3'h6: nxt_ratio = RATIO_X12;
         3'h7: nxt_ratio = RATIO_DEFAULT; // Reserved falls back to the safe ratio
      endcase
   end

   // Caught by a clocked process after release, never by the reset itself
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_taken_ff <= 1'b0;
         core_ratio_ff <= RATIO_DEFAULT;
         ratio_reserved_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         strap_taken_ff <= 1'b1;
         core_ratio_ff <= nxt_ratio;
         ratio_reserved_ff <= (core_ratio_straps == RATIO_RESERVED);
      end
   end

   // ----------------------------------------
   // Rate enables: system, on-chip bus, link
   // ----------------------------------------
   logic [3:0] sys_cnt_ff;
   logic bus_phase_ff;
   logic [LINK_DIV_W-1:0] link_cnt_ff;

   // System-rate enable every ratio core cycles; ratio 4 keeps the 1/4 limit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_cnt_ff <= 4'h0;
         ext_bus_en_ff <= 1'b0;
      end else if (sys_cnt_ff >= core_ratio_ff - 4'h1) begin
         sys_cnt_ff <= 4'h0;
         ext_bus_en_ff <= 1'b1;
      end else begin
         sys_cnt_ff <= sys_cnt_ff + 4'h1;
         ext_bus_en_ff <= 1'b0;
      end
   end

   // Half-rate bus enable; soft core reset leaves it running
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_phase_ff <= 1'b0;
         onchip_bus_clock_en_ff <= 1'b0;
      end else begin
         bus_phase_ff <= ~bus_phase_ff;
         onchip_bus_clock_en_ff <= bus_phase_ff;
      end
   end

   // Link enable; a divisor of 0 or 1 gives the full core rate
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_cnt_ff <= '0;
         link_clk_en_ff <= 1'b0;
      end else if (link_cnt_ff + LINK_DIV_W'(1) >= link_divisor) begin
         link_cnt_ff <= '0;
         link_clk_en_ff <= 1'b1;
      end else begin
         link_cnt_ff <= link_cnt_ff + LINK_DIV_W'(1);
         link_clk_en_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Core sequencing and boot selection
   // ----------------------------------------
   core_state_t core_state_ff;
   logic loader_sent_ff;
   logic core_go;
   logic [31:0] nxt_start;

   // Lowest-numbered active line wins when several fire together
   always_comb begin
      core_go = 1'b0;
      nxt_start = START_LOADED;
      if (boot_mode == BOOT_NONE) begin
         if (boot_interrupt_lines[0]) begin
            core_go = 1'b1;
            nxt_start = START_LINE0;
         end else if (boot_interrupt_lines[1]) begin
            core_go = 1'b1;
            nxt_start = START_LINE1;
         end else if (boot_interrupt_lines[2]) begin
            core_go = 1'b1;
            nxt_start = START_LINE2;
         end else if (boot_interrupt_lines[3]) begin
            core_go = 1'b1;
            nxt_start = START_LINE3;
         end
      end else begin
         core_go = loader_done;
      end
   end

   // Soft reset returns only the core to held; everything else untouched
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_state_ff <= CORE_HELD;
         core_reset_n_ff <= 1'b0;
         core_run_ff <= 1'b0;
         start_addr_ff <= START_LOADED;
         irq_enable_ff <= 4'h0;
      end else if (core_soft_reset_bit) begin
         core_state_ff <= CORE_HELD;
         core_reset_n_ff <= 1'b0;
         core_run_ff <= 1'b0;
         irq_enable_ff <= 4'h0;
      end else begin
         unique case (core_state_ff)
            CORE_HELD: begin
               if (reset_done_n_ff && dram_ready_ff && strap_taken_ff) begin
                  core_state_ff <= CORE_IDLE;
                  core_reset_n_ff <= 1'b1;
                  irq_enable_ff <= IRQ_EN_RESET;
               end
            end
            CORE_IDLE: begin
               if (core_go) begin
                  core_state_ff <= CORE_RUN;
                  start_addr_ff <= nxt_start;
                  core_run_ff <= 1'b1;
               end
            end
            CORE_RUN: begin
               core_run_ff <= 1'b1;
            end
            default: begin
               core_state_ff <= CORE_HELD;
            end
         endcase
      end
   end

   // Instruction enable every core cycle while running
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_en_ff <= 1'b0;
      end else begin
         instr_en_ff <= (core_state_ff == CORE_RUN) && !core_soft_reset_bit;
      end
   end

   // One start pulse to the loader per chip reset, for the three boot methods
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         loader_sent_ff <= 1'b0;
         loader_start_ff <= 1'b0;
      end else begin
         loader_start_ff <= 1'b0;
         if (!loader_sent_ff && core_state_ff == CORE_IDLE && boot_mode != BOOT_NONE) begin
            loader_sent_ff <= 1'b1;
            loader_start_ff <= 1'b1;
         end
      end
   end

endmodule : reset_boot_clock_sequencer

// [tb/rbc_asserts.sv]
// Checker for the sequencer: clock strobes, reset release and core starts.
// Assumes straps move only while rst_n is low; bound to every instance.
`timescale 1ns/1ns
module rbc_asserts
   import rbc_pkg::*;
#(
   parameter int DONE_CYCLES = RST_DONE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] core_ratio_straps,
   input wire logic [1:0] boot_mode,
   input wire logic [3:0] boot_interrupt_lines,
   input wire logic core_soft_reset_bit,
   input wire logic reset_done_n_ff,
   input wire logic core_reset_n_ff,
   input wire logic [3:0] core_ratio_ff,
   input wire logic ext_bus_en_ff,
   input wire logic onchip_bus_clock_en_ff,
   input wire logic instr_en_ff,
   input wire logic core_run_ff,
   input wire logic [31:0] start_addr_ff,
   input wire logic [3:0] irq_enable_ff
);
   logic [3:0] rat [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
   logic [15:0] up_ff;
   logic [4:0] gap_ff;
   logic seen_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Cycles since release and since the last system-rate strobe; saturate to avoid wrap
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_ff <= 16'h0000;
         gap_ff <= 5'h00;
         seen_ff <= 1'b0;
      end else begin
         up_ff <= (up_ff == 16'hffff) ? up_ff : up_ff + 16'h0001;
         gap_ff <= ext_bus_en_ff ? 5'h01 : gap_ff + {4'h0, gap_ff != 5'h1f};
         seen_ff <= seen_ff | ext_bus_en_ff;
      end
   end
   bus_half_rate_a: assert property (onchip_bus_clock_en_ff |=> !onchip_bus_clock_en_ff ##1
      onchip_bus_clock_en_ff) else $error("on-chip strobe not every second cycle");
   ext_rate_a: assert property (ext_bus_en_ff && seen_ff |-> gap_ff == {1'b0, core_ratio_ff})
      else $error("system-rate strobe gap wrong");
   ratio_map_a: assert property (reset_done_n_ff |-> core_ratio_ff == rat[core_ratio_straps])
      else $error("ratio decode wrong");
   done_time_a: assert property ($rose(reset_done_n_ff) |-> up_ff == DONE_CYCLES + 1)
      else $error("reset complete at wrong time");
   held_core_a: assert property (!reset_done_n_ff |-> !core_reset_n_ff && !core_run_ff)
      else $error("core out of reset too early");
   idle_wait_a: assert property ($rose(core_run_ff) && boot_mode == BOOT_NONE |->
      $past(boot_interrupt_lines) != 4'h0) else $error("core ran without interrupt");
   start_addr_a: assert property ($rose(core_run_ff) && boot_mode == BOOT_NONE |->
      start_addr_ff == ($past(boot_interrupt_lines[0]) ? 32'h3000_0000 : $past(boot_interrupt_lines[1]) ?
      32'h3800_0000 : $past(boot_interrupt_lines[2]) ? 32'h8000_0000 : 32'h0000_0000))
      else $error("start address wrong");
   run_instr_a: assert property ($rose(core_run_ff) |=> instr_en_ff)
      else $error("no instruction cycle after start");
   soft_core_a: assert property (core_soft_reset_bit |=> !core_reset_n_ff && !core_run_ff &&
      irq_enable_ff == 4'h0 && $stable(reset_done_n_ff)) else $error("soft reset scope wrong");
   irq_on_a: assert property (core_reset_n_ff && !core_soft_reset_bit |=> irq_enable_ff == 4'hf)
      else $error("reset interrupt enables missing");
endmodule : rbc_asserts
bind reset_boot_clock_sequencer rbc_asserts #(.DONE_CYCLES(DONE_CYCLES)) u_chk (.*);

// [tb/board_model.sv]
// Board side: reset source, strap pins and the reset-complete loop.
// Assumes the bench asks for resets and strap sets at clock edges.
`timescale 1ns/1ns
module board_model (
   input wire logic sys_clk,
   input wire logic rst_req,
   input wire logic [2:0] strap_sel,
   input wire logic reset_done_n_ff,
   output logic rst_n = 1'b0,
   output logic [2:0] core_ratio_straps = 3'h0,
   output logic por_in_n
);
   // Straps move only once reset is already low, as at a power cycle
   always @(posedge sys_clk) begin
      rst_n <= !rst_req;
      if (rst_req && !rst_n) begin
         core_ratio_straps <= strap_sel; // every ratio is at least 4
      end
   end
   // Reset-complete looped back to the DRAM power-on input
   assign por_in_n = reset_done_n_ff;
endmodule : board_model

// [tb/reset_boot_clock_sequencer_tb.sv]
// Bench for the sequencer: straps, start paths, soft reset and strobes.
// Assumes the board model and the bound checker beside the design.
`timescale 1ns/1ns
module reset_boot_clock_sequencer_tb;
   import rbc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_req = 1'b1;
   logic [2:0] strap_sel = 3'h0;
   logic [1:0] boot_mode = BOOT_NONE;
   logic [3:0] boot_interrupt_lines = 4'h0;
   logic core_soft_reset_bit = 1'b0;
   logic loader_done = 1'b0;
   logic [3:0] link_divisor = 4'h0;
   wire logic rst_n, por_in_n, reset_done_n_ff, core_reset_n_ff, dram_ready_ff, ratio_reserved_ff;
   wire logic instr_en_ff, onchip_bus_clock_en_ff, ext_bus_en_ff, link_clk_en_ff, loader_start_ff, core_run_ff;
   wire logic [2:0] core_ratio_straps;
   wire logic [3:0] core_ratio_ff, irq_enable_ff;
   wire logic [31:0] start_addr_ff;
   int fails = 0;
   int num_checks = 0;
   int starts = 0;
   initial forever #4 sys_clk = ~sys_clk;
   reset_boot_clock_sequencer #(.DONE_CYCLES(4)) dut (.*);
   board_model u_board (.*);
   // Loader kick-offs, counted mid-cycle so the launching edge never races the count
   always @(negedge sys_clk) if (loader_start_ff === 1'b1) starts++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // Bounded wait: 0 for core out of reset, 1 for core running
   task automatic wait_for(input int sel);
      for (int i = 0; i < 400; i++) begin
         @(posedge sys_clk);
         #1;
         if ((sel == 0 ? core_reset_n_ff : core_run_ff) === 1'b1) return;
      end
      fails++;
      test_done();
   endtask : wait_for
   // Pulses of one strobe over a window: 0 on-chip bus, 1 link
   task automatic cnt(input int sel, input int cyc, output int n);
      n = 0;
      repeat (cyc) begin
         @(posedge sys_clk);
         #1;
         n += (sel == 0) ? onchip_bus_clock_en_ff : link_clk_en_ff;
      end
   endtask : cnt
   task automatic power_up(input logic [2:0] s, input logic [1:0] m);
      @(posedge sys_clk);
      rst_req <= 1'b1;
      strap_sel <= s;
      boot_mode <= m;
      boot_interrupt_lines <= 4'h0;
      repeat (3) @(posedge sys_clk);
      rst_req <= 1'b0;
      wait_for(0);
   endtask : power_up
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_ratio;
      logic [3:0] exp_rat [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
      int a;
      int b;
      for (int s = 0; s < 8; s++) begin
         power_up(s[2:0], BOOT_NONE);
         a = 0;
         b = 0;
         for (int i = 1; i < 40; i++) begin
            @(posedge sys_clk);
            #1;
            if (ext_bus_en_ff === 1'b1 && a != 0 && b == 0) b = i;
            if (ext_bus_en_ff === 1'b1 && a == 0) a = i;
         end
         check(32'(b - a), {28'h000_0000, exp_rat[s]});
         check(ratio_reserved_ff, s == 7);
      end
      $display("ratio test done");
   endtask : test_ratio
   task automatic test_noboot;
      logic [3:0] pat [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc};
      logic [31:0] ex [5] = '{32'h3000_0000, 32'h3800_0000, 32'h8000_0000, 32'h0000_0000, 32'h8000_0000};
      for (int k = 0; k < 5; k++) begin
         power_up(3'h0, BOOT_NONE);
         repeat (5) @(posedge sys_clk);
         #1;
         check(core_run_ff, 1'b0);
         check(irq_enable_ff, 4'hf);
         check(dram_ready_ff, 1'b1);
         @(posedge sys_clk);
         boot_interrupt_lines <= pat[k];
         wait_for(1);
         check(start_addr_ff, ex[k]);
         @(posedge sys_clk);
         #1;
         check(instr_en_ff, 1'b1);
      end
      $display("no-boot test done");
   endtask : test_noboot
   // Core-only reset while the bus strobes and reset-complete keep going
   task automatic test_soft;
      int n;
      @(posedge sys_clk);
      core_soft_reset_bit <= 1'b1;
      boot_interrupt_lines <= 4'h0;
      cnt(0, 8, n);
      check(n, 4);
      check({core_reset_n_ff, core_run_ff, irq_enable_ff, reset_done_n_ff}, 7'h01);
      @(posedge sys_clk);
      core_soft_reset_bit <= 1'b0;
      boot_interrupt_lines <= 4'h2;
      wait_for(1);
      check(start_addr_ff, 32'h3800_0000);
      $display("soft reset test done");
   endtask : test_soft
   task automatic test_link;
      int n;
      @(posedge sys_clk);
      link_divisor <= 4'h3;
      repeat (20) @(posedge sys_clk);
      cnt(1, 12, n);
      check(n, 4);
      @(posedge sys_clk);
      link_divisor <= 4'h0;
      repeat (4) @(posedge sys_clk);
      cnt(1, 6, n);
      check(n, 6);
      $display("link test done");
   endtask : test_link
   // Loader modes ignore boot lines and start on loader completion
   task automatic test_boot;
      int base;
      for (int m = 0; m < 3; m++) begin
         base = starts;
         power_up(3'h0, m[1:0]);
         @(posedge sys_clk);
         boot_interrupt_lines <= 4'hf;
         repeat (6) @(posedge sys_clk);
         #1;
         check(core_run_ff, 1'b0);
         check(starts - base, 1);
         @(posedge sys_clk);
         loader_done <= 1'b1;
         wait_for(1);
         check(start_addr_ff, 32'h0000_0000);
         @(posedge sys_clk);
         loader_done <= 1'b0;
      end
      $display("boot test done");
   endtask : test_boot
   initial begin
      test_ratio();
      test_noboot();
      test_soft();
      test_link();
      test_boot();
      test_done();
   end
endmodule : reset_boot_clock_sequencer_tb
